//--- src/refresh_timer_pkg.sv
// Package with register map, field positions, reset values and tick select codes.
`default_nettype none
package refresh_timer_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_GEOMETRY = 8'h00;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h04;
    localparam logic [7:0] OFS_TICK_COUNT = 8'h08;
    localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h0C;
    localparam logic [7:0] OFS_REFRESH_CTRL = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [15:0] WRITE_KEY = 16'hA55A;
    localparam int KEY_LSB = 16;
    localparam int ROW_LSB = 3;
    localparam int COL_LSB = 0;
    localparam int CMF_BIT = 7;
    localparam int TICK_LSB = 3;
    localparam int REFRESH_ENABLE_BIT_BIT = 0;
    localparam int BURST_LSB = 1;
    localparam logic [4:0] GEOMETRY_RESET = 5'h00;
    localparam logic [2:0] TICK_SEL_RESET = 3'h0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [9:0] PRESCALE_RESET = 10'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        TICK_STOP, TICK_DIV4, TICK_DIV16, TICK_DIV64, TICK_DIV256, TICK_DIV1024,
        TICK_RSVD6, TICK_RSVD7
    } tick_sel_t;
endpackage
`default_nettype wire

//--- src/sdram_refresh_timer_config.sv
// Geometry config, refresh timer with compare flag, refresh request and burst, AXI4-Lite slave.
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`default_nettype none
// Contract
// - Row field 00/01/10 gives 11/12/13 row bits; 11 forbidden.
// - Column field 00/01/10 gives 8/9/10 column bits; 11 forbidden.
// - Geometry bits 7..5 and 2 read zero; software writes zero.
// - Timer control writes take effect only with key in upper half.
// - Timer control bits 31..8 read zero; bits 15..8 written zero.
// - Compare flag sets when tick counter equals period limit, unless tick select is stop or a reserved code.
// - Flag clears on zero write only after a read saw it set.
// - Tick select picks stop or bus clock divided by 4..1024.
// - Timer control bit 6 reads zero; software writes zero.
// - Counter counts ticks, clears on match, wraps after 255.
// - Enabled match raises pending request; a match while one is unserved is dropped.
// - Each served request issues a burst of 1,2,4,6 or 8 refreshes.
module sdram_refresh_timer_config (
    // Clock, reset and enable.
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic CLK_EN,
    // AXI4-Lite write channels.
    input wire logic [refresh_timer_pkg::ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read channels.
    input wire logic [refresh_timer_pkg::ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Refresh interface toward the command sequencer.
    input wire logic REFRESH_DONE,
    output logic REFRESH_STROBE,
    output logic REQUEST_PENDING,
    // Geometry decoded for the address mux.
    output logic [3:0] ROW_BITS,
    output logic [3:0] COL_BITS,
    // Interrupt.
    output logic IRQ
);
    import refresh_timer_pkg::*;

    logic [4:0] geometry;
    logic [2:0] tick_sel;
    logic compare_match_flag;
    logic cmf_seen;
    logic [7:0] tick_count;
    logic [7:0] period_limit;
    logic refresh_en;
    logic [2:0] burst_sel;
    logic [9:0] prescale;
    logic tick;
    logic match;
    logic [3:0] burst_left;
    logic [3:0] burst_total;
    logic irq_status;
    logic irq_mask;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic do_write;
    logic [31:0] next_rdata;
    logic next_rresp_err;
    logic key_ok;

    // Write address and data are captured independently, in either order.
    assign AWREADY = !aw_held && !BVALID;
    assign WREADY = !w_held && !BVALID;
    assign do_write = aw_held && w_held && !BVALID;
    assign key_ok = (w_data[31:KEY_LSB] == WRITE_KEY);

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end else if (CLK_EN) begin
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= (aw_addr > OFS_IRQ_MASK || aw_addr[1:0] != 2'h0) ? RESP_SLVERR
                                                                          : RESP_OKAY;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // Geometry register; only the row and column fields are stored, reserved bits drop.
    // Byte strobes are not used: every write is taken as a whole word.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            geometry <= GEOMETRY_RESET;
        end else if (CLK_EN && do_write && aw_addr == OFS_GEOMETRY) begin
            geometry <= {w_data[ROW_LSB+1:ROW_LSB], 1'b0, w_data[COL_LSB+1:COL_LSB]};
        end
    end

    // Row and column widths follow the two-bit codes; the forbidden code maps to zero.
    always_comb begin
        case (geometry[4:3])
            2'h0: ROW_BITS = 4'hB;
            2'h1: ROW_BITS = 4'hC;
            2'h2: ROW_BITS = 4'hD;
            default: ROW_BITS = 4'h0;
        endcase
        case (geometry[1:0])
            2'h0: COL_BITS = 4'h8;
            2'h1: COL_BITS = 4'h9;
            2'h2: COL_BITS = 4'hA;
            default: COL_BITS = 4'h0;
        endcase
    end

    // Keyed registers: tick select, counter and limit ignore writes without the key.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tick_sel <= TICK_SEL_RESET;
            period_limit <= LIMIT_RESET;
            refresh_en <= 1'b0;
            burst_sel <= 3'h0;
            irq_mask <= 1'b0;
        end else if (CLK_EN && do_write) begin
            if (aw_addr == OFS_TIMER_CTRL && key_ok) begin
                tick_sel <= w_data[TICK_LSB+2:TICK_LSB];
            end else if (aw_addr == OFS_PERIOD_LIMIT && key_ok) begin
                period_limit <= w_data[7:0];
            end else if (aw_addr == OFS_REFRESH_CTRL) begin
                refresh_en <= w_data[REFRESH_ENABLE_BIT_BIT];
                burst_sel <= w_data[BURST_LSB+2:BURST_LSB];
            end else if (aw_addr == OFS_IRQ_MASK) begin
                irq_mask <= w_data[0];
            end
        end
    end

    // Free-running prescaler; each tap ticks once per full division.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            prescale <= PRESCALE_RESET;
        end else if (CLK_EN) begin
            prescale <= prescale + 10'h001;
        end
    end

    always_comb begin
        case (tick_sel)
            TICK_DIV4: tick = (prescale[1:0] == 2'h3);
            TICK_DIV16: tick = (prescale[3:0] == 4'hF);
            TICK_DIV64: tick = (prescale[5:0] == 6'h3F);
            TICK_DIV256: tick = (prescale[7:0] == 8'hFF);
            TICK_DIV1024: tick = (prescale == 10'h3FF);
            default: tick = 1'b0;
        endcase
    end

    assign match = (tick_count == period_limit) && tick_sel != TICK_STOP
                   && tick_sel != TICK_RSVD6 && tick_sel != TICK_RSVD7;

    // Counter clears on match and wraps naturally after 255.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tick_count <= COUNT_RESET;
        end else if (CLK_EN) begin
            if (do_write && aw_addr == OFS_TICK_COUNT && key_ok) begin
                tick_count <= w_data[7:0];
            end else if (match) begin
                tick_count <= COUNT_RESET;
            end else if (tick) begin
                tick_count <= tick_count + 8'h01;
            end
        end
    end

    // Flag: the match wins over a clearing write in the same cycle.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            compare_match_flag <= 1'b0;
            cmf_seen <= 1'b0;
        end else if (CLK_EN) begin
            if (match) begin
                compare_match_flag <= 1'b1;
            end else if (do_write && aw_addr == OFS_TIMER_CTRL && key_ok
                         && !w_data[CMF_BIT] && cmf_seen) begin
                compare_match_flag <= 1'b0;
                cmf_seen <= 1'b0;
            end
            if (ARVALID && ARREADY && ARADDR == OFS_TIMER_CTRL && compare_match_flag) begin
                cmf_seen <= 1'b1;
            end
        end
    end

    // Request pends until served; a new match just re-asserts it, so none stack up.
    // Burst counter walks the refresh strobes one per acknowledged refresh.
    always_comb begin
        case (burst_sel)
            3'h0: burst_total = 4'h1;
            3'h1: burst_total = 4'h2;
            3'h2: burst_total = 4'h4;
            3'h3: burst_total = 4'h6;
            default: burst_total = 4'h8;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            REQUEST_PENDING <= 1'b0;
            burst_left <= 4'h0;
        end else if (CLK_EN) begin
            if (burst_left != 4'h0 && REFRESH_DONE) begin
                burst_left <= burst_left - 4'h1;
            end else if (burst_left == 4'h0 && REQUEST_PENDING) begin
                burst_left <= burst_total;
                REQUEST_PENDING <= 1'b0;
            end
            if (match && refresh_en) begin
                REQUEST_PENDING <= 1'b1;
            end
        end
    end
    assign REFRESH_STROBE = (burst_left != 4'h0);

    // Sticky interrupt status, cleared by writing one; set wins.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            irq_status <= 1'b0;
        end else if (CLK_EN) begin
            if (match) begin
                irq_status <= 1'b1;
            end else if (do_write && aw_addr == OFS_IRQ_STATUS && w_data[0]) begin
                irq_status <= 1'b0;
            end
        end
    end
    assign IRQ = irq_status && irq_mask;

    // Read decode; unused and reserved bits read zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp_err = 1'b0;
        if (ARADDR == OFS_GEOMETRY) begin
            next_rdata[4:0] = geometry;
        end else if (ARADDR == OFS_TIMER_CTRL) begin
            next_rdata[7:0] = {compare_match_flag, 1'b0, tick_sel, 3'h0};
        end else if (ARADDR == OFS_TICK_COUNT) begin
            next_rdata[7:0] = tick_count;
        end else if (ARADDR == OFS_PERIOD_LIMIT) begin
            next_rdata[7:0] = period_limit;
        end else if (ARADDR == OFS_REFRESH_CTRL) begin
            next_rdata[3:0] = {burst_sel, refresh_en};
        end else if (ARADDR == OFS_IRQ_STATUS) begin
            next_rdata[0] = irq_status;
        end else if (ARADDR == OFS_IRQ_MASK) begin
            next_rdata[0] = irq_mask;
        end else begin
            next_rresp_err = 1'b1;
        end
    end

    assign ARREADY = !RVALID;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= RESP_OKAY;
        end else if (CLK_EN) begin
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RDATA <= next_rdata;
                RRESP <= next_rresp_err ? RESP_SLVERR : RESP_OKAY;
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // Assertions on the timer and flag path.
    a_match_sets_flag: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CLK_EN && match |=> compare_match_flag)
        else $error("flag not set on match");
    a_match_clears_count: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CLK_EN && match && !do_write |=> tick_count == 8'h00)
        else $error("counter not cleared on match");
    a_count_wraps: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CLK_EN && tick && !match && !do_write && tick_count == 8'hFF
        |=> tick_count == 8'h00) else $error("counter did not wrap after 255");
    a_stop_holds_count: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CLK_EN && tick_sel inside {3'h0, 3'h6, 3'h7} && !do_write |=> $stable(tick_count))
        else $error("counter moved while stopped");
    a_unkeyed_ignored: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CLK_EN && do_write && aw_addr == OFS_TIMER_CTRL && !key_ok |=> $stable(tick_sel))
        else $error("unkeyed write took effect");
    a_flag_clear_needs_read: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $fell(compare_match_flag) |-> $past(cmf_seen))
        else $error("flag cleared without read");
    // A low clock enable must hold the tick counter, prescaler and compare flag where they stand.
    a_freeze_holds: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !CLK_EN |=> $stable(tick_count) && $stable(prescale) && $stable(compare_match_flag))
        else $error("state moved while clock enable low");

    // Assertions on read-back and geometry decode.
    a_ctrl_upper_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        ARADDR == OFS_TIMER_CTRL |-> next_rdata[31:8] == 24'h0 && !next_rdata[6])
        else $error("reserved control bits nonzero");
    a_geom_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        ARADDR == OFS_GEOMETRY |-> next_rdata[7:5] == 3'h0 && !next_rdata[2])
        else $error("reserved geometry bits nonzero");
    a_row_width: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        geometry[4:3] == 2'h1 |-> ROW_BITS == 4'hC)
        else $error("row width wrong");
    a_col_width: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        geometry[1:0] == 2'h2 |-> COL_BITS == 4'hA)
        else $error("col width wrong");

    // Assertions on the refresh request and burst path.
    a_request_on_match: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CLK_EN && match && refresh_en |=> REQUEST_PENDING)
        else $error("match raised no request");
    a_burst_loads: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CLK_EN && burst_left == 4'h0 && REQUEST_PENDING |=> burst_left == $past(burst_total))
        else $error("burst not loaded from pending request");
    a_done_consumes: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        CLK_EN && burst_left != 4'h0 && REFRESH_DONE |=> burst_left == $past(burst_left) - 4'h1)
        else $error("refresh done did not consume one strobe");
endmodule // sdram_refresh_timer_config
`default_nettype wire

//--- tb/refresh_sequencer_model.sv
// Behavioural refresh command sequencer that answers the refresh strobe of the timer block.
`default_nettype none
module refresh_sequencer_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Refresh handshake and pacing controls.
    input wire logic strobe,
    input wire logic go,
    input wire logic [3:0] lag,
    output logic done,
    output int served
);
    logic [3:0] wait_cnt;

    // One refresh cycle takes lag plus one clocks, and go low models a busy sequencer.
    // The guard on done stops a single strobe level from being counted twice.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            wait_cnt <= 4'h0;
            served <= 0;
        end else begin
            done <= 1'b0;
            if (strobe && go && !done) begin
                if (wait_cnt >= lag) begin
                    done <= 1'b1;
                    served <= served + 1;
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule // refresh_sequencer_model
`default_nettype wire

//--- tb/test_sdram_refresh_timer_config.sv
// Self-checking bench for the SDRAM geometry and refresh timer block.
`default_nettype none
module test_sdram_refresh_timer_config;
    import refresh_timer_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic go = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] lag = 4'h0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic [31:0] v;
    logic awready, wready, bvalid, arready, rvalid, strobe, pending, irq, done;
    logic [1:0] bresp, rresp, resp;
    logic [3:0] row_bits, col_bits;
    int served, base;
    int bad_count = 0;
    int compares = 0;
    int burst_len[5] = '{1, 2, 4, 6, 8};

    // Byte strobes and ready lines are held on; everything else is exercised.
    sdram_refresh_timer_config i_sdram_refresh_timer_config (
        .CLK_SYS(clk_sys), .RESETN(resetn), .CLK_EN(clk_en),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(1'b1),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(1'b1), .REFRESH_DONE(done), .REFRESH_STROBE(strobe),
        .REQUEST_PENDING(pending), .ROW_BITS(row_bits), .COL_BITS(col_bits), .IRQ(irq)
    );

    refresh_sequencer_model i_refresh_sequencer_model (
        .clk(clk_sys), .rst_n(resetn), .strobe(strobe), .go(go), .lag(lag), .done(done),
        .served(served)
    );

    // Free-running 10 MHz system clock.
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        bad_count++;
        $display("Error %s expected answer seen timeout", what);
        tally_and_finish();
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Write cycle: address and data offered together, each released once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        resp = bresp;
        if (n >= 50) give_up("write");
    endtask

    // Keyed write places the unlock key in the upper half, zero in bits 15..8 and the data byte below.
    task automatic kw(input logic [7:0] a, input logic [7:0] d);
        wr(a, {WRITE_KEY, 8'h00, d});
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        v = rdata;
        resp = rresp;
        if (n >= 50) give_up("read");
    endtask

    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(what, v, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // A hung handshake or partner is cut short here.
    initial begin
        #5000000;
        give_up("run");
    end

    // Main sequence of register traffic and refresh scenarios.
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        check("row_bits", {28'h0, row_bits}, 32'h0000000B);
        check("col_bits", {28'h0, col_bits}, 32'h00000008);
        rc("geometry", OFS_GEOMETRY, 32'h00000000);
        rc("timer_ctrl", OFS_TIMER_CTRL, 32'h00000000);
        rd(8'h40);
        check("rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(8'h1C, 32'h00000000);
        check("bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        // Without the key nothing lands; reserved codes must not set the flag at limit 0.
        wr(OFS_TIMER_CTRL, 32'h00000030);
        rc("unkeyed", OFS_TIMER_CTRL, 32'h00000000);
        kw(OFS_TIMER_CTRL, 8'h30);
        idle(20);
        rc("code6", OFS_TIMER_CTRL, 32'h00000030);
        wr(OFS_TIMER_CTRL, 32'hA55B0000);
        rc("bad_key", OFS_TIMER_CTRL, 32'h00000030);
        kw(OFS_TIMER_CTRL, 8'h38);
        idle(20);
        rc("code7", OFS_TIMER_CTRL, 32'h00000038);
        kw(OFS_TIMER_CTRL, 8'h00);
        idle(20);
        rc("code0", OFS_TIMER_CTRL, 32'h00000000);
        // Open-bank policy lives outside this block, so no bus width is set up here.
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 3; c++) begin
                wr(OFS_GEOMETRY, 32'((r << 3) | c));
                rc("geometry", OFS_GEOMETRY, 32'((r << 3) | c));
                check("row_bits", {28'h0, row_bits}, 32'(11 + r));
                check("col_bits", {28'h0, col_bits}, 32'(8 + c));
            end
        end
        // Flag sets on match, survives a blind clear, clears after a read saw it.
        kw(OFS_PERIOD_LIMIT, 8'h03);
        kw(OFS_TIMER_CTRL, 8'h08);
        idle(60);
        kw(OFS_TIMER_CTRL, 8'h00);
        rc("flag", OFS_TIMER_CTRL, 32'h00000080);
        wr(OFS_TIMER_CTRL, 32'h00000000);
        rc("flag", OFS_TIMER_CTRL, 32'h00000080);
        check("irq", {31'h0, irq}, 32'h00000000);
        wr(OFS_IRQ_MASK, 32'h00000001);
        check("irq", {31'h0, irq}, 32'h00000001);
        wr(OFS_IRQ_STATUS, 32'h00000001);
        check("irq", {31'h0, irq}, 32'h00000000);
        rc("irq_status", OFS_IRQ_STATUS, 32'h00000000);
        kw(OFS_TIMER_CTRL, 8'h00);
        rc("flag", OFS_TIMER_CTRL, 32'h00000000);
        // A limit of one is reached from 0xFE only if the counter wraps through zero.
        kw(OFS_PERIOD_LIMIT, 8'h01);
        kw(OFS_TICK_COUNT, 8'hFE);
        kw(OFS_TIMER_CTRL, 8'h08);
        idle(20);
        kw(OFS_TIMER_CTRL, 8'h00);
        rc("wrap_flag", OFS_TIMER_CTRL, 32'h00000080);
        // Four periods of each divider should give four ticks, give or take prescaler phase.
        kw(OFS_PERIOD_LIMIT, 8'hFF);
        for (int c = 1; c <= 5; c++) begin
            kw(OFS_TICK_COUNT, 8'h00);
            kw(OFS_TIMER_CTRL, 8'(c << 3));
            idle(16 << (2 * c - 2));
            kw(OFS_TIMER_CTRL, 8'h00);
            rd(OFS_TICK_COUNT);
            check("tick_count", {31'h0, v >= 32'd3 && v <= 32'd5}, 32'h00000001);
        end
        // Clock enable low for 40 cycles must freeze counter and prescaler mid-run.
        kw(OFS_TICK_COUNT, 8'h00);
        kw(OFS_TIMER_CTRL, 8'h08);
        clk_en <= 1'b0;
        idle(40);
        clk_en <= 1'b1;
        kw(OFS_TIMER_CTRL, 8'h00);
        rd(OFS_TICK_COUNT);
        check("frozen_count", {31'h0, v <= 32'd1}, 32'h00000001);
        // Stalled sequencer: one burst plus one held request, later matches are dropped.
        kw(OFS_PERIOD_LIMIT, 8'h03);
        for (int k = 0; k < 5; k++) begin
            go <= 1'b0;
            lag <= 4'(k);
            wr(OFS_REFRESH_CTRL, 32'((k << 1) | 1));
            kw(OFS_TIMER_CTRL, 8'h08);
            idle(150);
            kw(OFS_TIMER_CTRL, 8'h00);
            check("pending", {31'h0, pending}, 32'h00000001);
            base = served;
            go <= 1'b1;
            for (int n = 0; n < 400 && (strobe !== 1'b0 || pending !== 1'b0); n++) begin
                @(posedge clk_sys);
            end
            if (strobe !== 1'b0 || pending !== 1'b0) give_up("burst");
            check("served", 32'(served - base), 32'(2 * burst_len[k]));
        end
        tally_and_finish();
    end
endmodule // test_sdram_refresh_timer_config
`default_nettype wire
